//--- ecr_pkg.sv
// Shared constants and types for the configuration register block.
package ecr_pkg;

  // Device address byte and word address checks.
  localparam logic [3:0] DEV_TYPE      = 4'hb;
  localparam int         WA_HI_A15_POS = 7;
  localparam int         WA_HI_A11_POS = 3;
  localparam int         WA_HI_A10_POS = 2;

  // Register field positions within the 16-bit word.
  localparam int ECC_POS    = 15;
  localparam int SCHEME_POS = 9;
  localparam int LOCK_POS   = 8;
  localparam int HI_SCHEME  = 1;
  localparam int HI_LOCK    = 0;

  // Zone selection from array address bits.
  localparam int ZONE_MSB   = 14;
  localparam int ZONE_LSB   = 12;
  localparam int ZONE_BYTES = 4096;

  // Confirmation byte values.
  localparam logic [7:0] CONFIRM_LOCK = 8'h99;
  localparam logic [7:0] CONFIRM_OPEN = 8'h66;

  // Byte counts of a register write frame.
  localparam logic [2:0] WR_DATA_BYTES = 3'h3;
  localparam logic [2:0] DATA_CNT_MAX  = 3'h4;
  localparam logic [2:0] HDR_LAST      = 3'h3;
  localparam logic [2:0] LAST_BIT      = 3'h7;

  // Reset and factory default values.
  localparam logic       ECC_RESET    = 1'b0;
  localparam logic       SCHEME_RESET = 1'b0;
  localparam logic       LOCK_RESET   = 1'b0;
  localparam logic [7:0] ZONE_RESET   = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_HACK
  } ecr_link_state_t;

endpackage

//--- ecr_xfer.sv
// Toggle handshake that carries one word between two clock domains.
`timescale 1ns/10ps
module ecr_xfer #(
  parameter int W = 16
) (
  // Source domain.
  input  wire logic         src_clk_i,
  input  wire logic         src_rst_i,
  input  wire logic         src_valid_i,
  input  wire logic [W-1:0] src_data_i,
  output logic              src_ready_o,
  // Destination domain.
  input  wire logic         dst_clk_i,
  input  wire logic         dst_rst_i,
  output logic              dst_valid_o,
  output logic [W-1:0]      dst_data_o
);
  logic         req_tgl_reg;
  logic [W-1:0] data_reg;
  logic         ack_s1_reg;
  logic         ack_s2_reg;
  logic         req_s1_reg;
  logic         req_s2_reg;
  logic         req_s3_reg;
  logic         ack_tgl_reg;
  logic         dst_valid_reg;
  logic [W-1:0] dst_data_reg;
  wire          take = src_valid_i && src_ready_o;
  wire          arrive = req_s2_reg != req_s3_reg;

  // The held word stays still until the far side has toggled back.
  assign src_ready_o = ack_s2_reg == req_tgl_reg;
  assign dst_valid_o = dst_valid_reg;
  assign dst_data_o  = dst_data_reg;

  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      req_tgl_reg <= 1'b0;
      data_reg    <= '0;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      if (take) begin
        req_tgl_reg <= ~req_tgl_reg;
        data_reg    <= src_data_i;
      end
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      req_s1_reg    <= 1'b0;
      req_s2_reg    <= 1'b0;
      req_s3_reg    <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      dst_valid_reg <= 1'b0;
      dst_data_reg  <= '0;
    end else begin
      req_s1_reg    <= req_tgl_reg;
      req_s2_reg    <= req_s1_reg;
      req_s3_reg    <= req_s2_reg;
      dst_valid_reg <= arrive;
      if (arrive) begin
        dst_data_reg <= data_reg;
        ack_tgl_reg  <= req_s2_reg;
      end
    end
  end

endmodule // ecr_xfer

//--- ecr_config_reg.sv
// Configuration register of a two-wire serial memory: link decode and protection.
`timescale 1ns/10ps
// How it works
// - Register is selected only when the address byte type code is 1011.
// - Address bits 3..1 must match chip-select pins; bit 0 picks read or write.
// - Two word address bytes are taken; only A15, A11 and A10 are checked.
// - Data moves high byte first, then low byte.
// - Bit 15 reads one when the last array read needed correction.
// - That latch clears on a clean read or on power-on reset.
// - Bits 14 to 10 always read zero.
// - Scheme bit one: write-protect pin ignored, zone bits guard the array.
// - Scheme bit zero (default): pin guards whole array and security register.
// - Lock bit one makes the register read-only forever; zero leaves it writable.
// - Zone bit n blocks writes to 4096-byte zone n independently.
// - Zone bits default to zero, every zone writable.
// - In pin scheme zone bits are ignored but a low byte is still sent.
// - Write happens only with exactly two data bytes plus one confirmation byte.
// - Confirmation must be 99h for lock one, 66h for lock zero.
// - Writes to a locked register are acknowledged but change nothing.
// - Reads wrap from the second byte back to the first while acked.
module ecr_config_reg (
  // System clock and reset.
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Two-wire link, synchronous to its own clock.
  input  wire logic        link_clk_i,
  input  wire logic        link_start_i,
  input  wire logic        link_stop_i,
  input  wire logic        link_sda_i,
  output logic             link_sda_o,
  output logic             link_sda_oe_o,
  // Pins.
  input  wire logic        chip_select_bit2_i,
  input  wire logic        chip_select_bit1_i,
  input  wire logic        chip_select_bit0_i,
  input  wire logic        wp_pin_i,
  // Array side.
  input  wire logic        array_read_done_i,
  input  wire logic        array_read_ecc_i,
  input  wire logic [14:0] array_wr_addr_i,
  output logic             array_wr_blocked_o,
  output logic             sec_wr_blocked_o,
  // Nonvolatile store.
  input  wire logic        nv_scheme_i,
  input  wire logic        nv_lock_i,
  input  wire logic [7:0]  nv_zone_i,
  output logic             nv_write_o,
  output logic             protect_scheme_select_o,
  output logic             lock_o,
  output logic [7:0]       zone_guard_bits_o
);

  function automatic logic zone_hit(input logic [7:0] zones, input logic [14:0] addr);
    zone_hit = zones[addr[ecr_pkg::ZONE_MSB:ecr_pkg::ZONE_LSB]];
  endfunction

  // ---------------- System domain ----------------
  logic        rst_q_reg;
  logic        wp_s1_reg;
  logic        wp_s2_reg;
  logic        ecc_used_flag_reg;
  logic        scheme_reg;
  logic        lock_reg;
  logic [7:0]  zone_guard_bits_reg;
  logic        nv_write_reg;
  logic        arr_blk_reg;
  logic        sec_blk_reg;
  logic [15:0] sent_reg;
  logic        sent_ok_reg;
  logic        wr_arrive;
  logic [23:0] wr_word;
  logic        stat_ready;

  wire        nv_load   = rst_q_reg && !sys_rst_i;
  wire [7:0]  wr_hi     = wr_word[23:16];
  wire [7:0]  wr_lo     = wr_word[15:8];
  wire [7:0]  wr_conf   = wr_word[7:0];
  wire [7:0]  conf_need = wr_hi[ecr_pkg::HI_LOCK] ? ecr_pkg::CONFIRM_LOCK
                                                  : ecr_pkg::CONFIRM_OPEN;
  wire        wr_ok     = wr_arrive && !lock_reg && wr_conf == conf_need;
  wire [15:0] cfg_word  = {ecc_used_flag_reg, 5'h00, scheme_reg, lock_reg,
                           zone_guard_bits_reg};
  wire        stat_send = stat_ready && (!sent_ok_reg || cfg_word != sent_reg);
  // Pin scheme guards everything from the pin; zone scheme ignores the pin.
  wire        arr_blk_next = scheme_reg ? zone_hit(zone_guard_bits_reg, array_wr_addr_i)
                                        : wp_s2_reg;
  wire        sec_blk_next = !scheme_reg && wp_s2_reg;

  assign array_wr_blocked_o      = arr_blk_reg;
  assign sec_wr_blocked_o        = sec_blk_reg;
  assign nv_write_o              = nv_write_reg;
  assign protect_scheme_select_o = scheme_reg;
  assign lock_o                  = lock_reg;
  assign zone_guard_bits_o       = zone_guard_bits_reg;

  always_ff @(posedge sys_clk_i) begin
    wp_s1_reg <= wp_pin_i;
    wp_s2_reg <= wp_s1_reg;
    rst_q_reg <= sys_rst_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ecc_used_flag_reg <= ecr_pkg::ECC_RESET;
    end else if (array_read_done_i) begin
      ecc_used_flag_reg <= array_read_ecc_i;
    end
  end

  // The persistent bits are restored from the store right after reset release.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scheme_reg          <= ecr_pkg::SCHEME_RESET;
      lock_reg            <= ecr_pkg::LOCK_RESET;
      zone_guard_bits_reg <= ecr_pkg::ZONE_RESET;
      nv_write_reg        <= 1'b0;
    end else if (nv_load) begin
      scheme_reg          <= nv_scheme_i;
      lock_reg            <= nv_lock_i;
      zone_guard_bits_reg <= nv_zone_i;
      nv_write_reg        <= 1'b0;
    end else begin
      nv_write_reg <= wr_ok;
      if (wr_ok) begin
        scheme_reg          <= wr_hi[ecr_pkg::HI_SCHEME];
        lock_reg            <= wr_hi[ecr_pkg::HI_LOCK];
        zone_guard_bits_reg <= wr_lo;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      arr_blk_reg <= 1'b0;
      sec_blk_reg <= 1'b0;
      sent_reg    <= '0;
      sent_ok_reg <= 1'b0;
    end else begin
      arr_blk_reg <= arr_blk_next;
      sec_blk_reg <= sec_blk_next;
      if (stat_send) begin
        sent_reg    <= cfg_word;
        sent_ok_reg <= 1'b1;
      end
    end
  end

  // ---------------- Link domain ----------------
  logic                     lrst_s1_reg;
  logic                     lrst_s2_reg;
  logic [2:0]               cs_s1_reg;
  logic [2:0]               cs_s2_reg;
  ecr_pkg::ecr_link_state_t state_reg, state_next;
  logic [2:0]               bit_reg, bit_next;
  logic [2:0]               byte_reg, byte_next;
  logic [2:0]               dcnt_reg, dcnt_next;
  logic [7:0]               shift_reg, shift_next;
  logic [7:0]               hi_reg, hi_next;
  logic [7:0]               lo_reg, lo_next;
  logic [7:0]               conf_reg, conf_next;
  logic                     rd_reg, rd_next;
  logic                     match_reg, match_next;
  logic                     addr_ok_reg, addr_ok_next;
  logic                     tx_sel_reg, tx_sel_next;
  logic                     sda_reg, sda_next;
  logic                     oe_reg, oe_next;
  logic                     wr_fire;
  logic [15:0]              cfg_view_reg;
  logic                     stat_arrive;
  logic [15:0]              stat_word;

  wire       lrst     = lrst_s2_reg;
  wire [7:0] rx_byte  = {shift_reg[6:0], link_sda_i};
  wire       dev_hit  = rx_byte[7:4] == ecr_pkg::DEV_TYPE
                        && rx_byte[3:1] == cs_s2_reg;
  wire       wa_ok    = rx_byte[ecr_pkg::WA_HI_A15_POS] && rx_byte[ecr_pkg::WA_HI_A11_POS]
                        && !rx_byte[ecr_pkg::WA_HI_A10_POS];
  wire [7:0] tx_cur   = tx_sel_reg ? cfg_view_reg[7:0] : cfg_view_reg[15:8];
  wire [7:0] tx_other = tx_sel_reg ? cfg_view_reg[15:8] : cfg_view_reg[7:0];
  wire       last_bit = bit_reg == ecr_pkg::LAST_BIT;
  wire       quiet    = !link_start_i && !link_stop_i;

  assign link_sda_o    = sda_reg;
  assign link_sda_oe_o = oe_reg;

  always_comb begin
    state_next   = state_reg;
    bit_next     = bit_reg;
    byte_next    = byte_reg;
    dcnt_next    = dcnt_reg;
    shift_next   = shift_reg;
    hi_next      = hi_reg;
    lo_next      = lo_reg;
    conf_next    = conf_reg;
    rd_next      = rd_reg;
    match_next   = match_reg;
    addr_ok_next = addr_ok_reg;
    tx_sel_next  = tx_sel_reg;
    sda_next     = 1'b0;
    oe_next      = 1'b0;
    wr_fire      = 1'b0;
    if (link_start_i) begin
      // A repeated start keeps the word address for the random read.
      state_next = ecr_pkg::ST_RX;
      bit_next   = '0;
      byte_next  = '0;
      dcnt_next  = '0;
      match_next = 1'b0;
    end else if (link_stop_i) begin
      wr_fire      = match_reg && !rd_reg && addr_ok_reg
                     && dcnt_reg == ecr_pkg::WR_DATA_BYTES;
      state_next   = ecr_pkg::ST_IDLE;
      addr_ok_next = 1'b0;
    end else begin
      case (state_reg)
        ecr_pkg::ST_RX: begin
          shift_next = rx_byte;
          bit_next   = bit_reg + 3'h1;
          if (last_bit) begin
            state_next = ecr_pkg::ST_ACK;
            oe_next    = 1'b1;
            byte_next  = (byte_reg < ecr_pkg::HDR_LAST) ? byte_reg + 3'h1 : byte_reg;
            if (byte_reg == 3'h0) begin
              match_next = dev_hit;
              rd_next    = rx_byte[0];
              if (!dev_hit) begin
                state_next = ecr_pkg::ST_IDLE;
                oe_next    = 1'b0;
              end
            end else if (byte_reg == 3'h1) begin
              addr_ok_next = wa_ok;
            end else if (byte_reg == ecr_pkg::HDR_LAST) begin
              if (dcnt_reg == 3'h0) hi_next = rx_byte;
              if (dcnt_reg == 3'h1) lo_next = rx_byte;
              if (dcnt_reg == 3'h2) conf_next = rx_byte;
              if (dcnt_reg < ecr_pkg::DATA_CNT_MAX) dcnt_next = dcnt_reg + 3'h1;
            end
          end
        end
        ecr_pkg::ST_ACK: begin
          bit_next = '0;
          if (!rd_reg) begin
            state_next = ecr_pkg::ST_RX;
          end else if (addr_ok_reg) begin
            state_next  = ecr_pkg::ST_TX;
            tx_sel_next = 1'b0;
            sda_next    = cfg_view_reg[15];
            oe_next     = 1'b1;
          end else begin
            state_next = ecr_pkg::ST_IDLE;
          end
        end
        ecr_pkg::ST_TX: begin
          if (last_bit) begin
            state_next = ecr_pkg::ST_HACK;
          end else begin
            bit_next = bit_reg + 3'h1;
            sda_next = tx_cur[3'h6 - bit_reg];
            oe_next  = 1'b1;
          end
        end
        ecr_pkg::ST_HACK: begin
          if (!link_sda_i) begin
            state_next  = ecr_pkg::ST_TX;
            bit_next    = '0;
            tx_sel_next = ~tx_sel_reg;
            sda_next    = tx_other[7];
            oe_next     = 1'b1;
          end else begin
            state_next = ecr_pkg::ST_IDLE;
          end
        end
        default: state_next = ecr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk_i) begin
    lrst_s1_reg <= sys_rst_i;
    lrst_s2_reg <= lrst_s1_reg;
    cs_s1_reg   <= {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};
    cs_s2_reg   <= cs_s1_reg;
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state_reg   <= ecr_pkg::ST_IDLE;
      bit_reg     <= '0;
      byte_reg    <= '0;
      dcnt_reg    <= '0;
      shift_reg   <= '0;
      hi_reg      <= '0;
      lo_reg      <= '0;
      conf_reg    <= '0;
      rd_reg      <= 1'b0;
      match_reg   <= 1'b0;
      addr_ok_reg <= 1'b0;
      tx_sel_reg  <= 1'b0;
      sda_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_reg     <= bit_next;
      byte_reg    <= byte_next;
      dcnt_reg    <= dcnt_next;
      shift_reg   <= shift_next;
      hi_reg      <= hi_next;
      lo_reg      <= lo_next;
      conf_reg    <= conf_next;
      rd_reg      <= rd_next;
      match_reg   <= match_next;
      addr_ok_reg <= addr_ok_next;
      tx_sel_reg  <= tx_sel_next;
      sda_reg     <= sda_next;
      oe_reg      <= oe_next;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      cfg_view_reg <= '0;
    end else if (stat_arrive) begin
      cfg_view_reg <= stat_word;
    end
  end

  // Write frames are far apart, so a request seen while busy cannot occur.
  ecr_xfer #(.W(24)) u_wr_xfer (
    .src_clk_i   (link_clk_i),
    .src_rst_i   (lrst),
    .src_valid_i (wr_fire),
    .src_data_i  ({hi_reg, lo_reg, conf_reg}),
    .src_ready_o (),
    .dst_clk_i   (sys_clk_i),
    .dst_rst_i   (sys_rst_i),
    .dst_valid_o (wr_arrive),
    .dst_data_o  (wr_word)
  );

  ecr_xfer #(.W(16)) u_stat_xfer (
    .src_clk_i   (sys_clk_i),
    .src_rst_i   (sys_rst_i),
    .src_valid_i (stat_send),
    .src_data_i  (cfg_word),
    .src_ready_o (stat_ready),
    .dst_clk_i   (link_clk_i),
    .dst_rst_i   (lrst),
    .dst_valid_o (stat_arrive),
    .dst_data_o  (stat_word)
  );

  // ---------------- Checks ----------------
  type_miss_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state_reg == ecr_pkg::ST_RX && last_bit && byte_reg == 3'h0 && quiet
     && rx_byte[7:4] != ecr_pkg::DEV_TYPE) |=> state_reg == ecr_pkg::ST_IDLE && !oe_reg)
    else $error("wrong type code was acknowledged");
  cs_miss_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state_reg == ecr_pkg::ST_RX && last_bit && byte_reg == 3'h0 && quiet
     && rx_byte[3:1] != cs_s2_reg) |=> !match_reg)
    else $error("chip select mismatch was accepted");
  word_addr_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state_reg == ecr_pkg::ST_RX && last_bit && byte_reg == 3'h1 && quiet)
    |=> addr_ok_reg == $past(wa_ok))
    else $error("word address check wrong");
  read_order_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state_reg == ecr_pkg::ST_ACK && rd_reg && addr_ok_reg && quiet)
    |=> oe_reg && !tx_sel_reg && sda_reg == $past(cfg_view_reg[15]))
    else $error("read did not start with high byte");
  read_wrap_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state_reg == ecr_pkg::ST_HACK && !link_sda_i && tx_sel_reg && quiet)
    |=> state_reg == ecr_pkg::ST_TX && !tx_sel_reg)
    else $error("read did not wrap to first byte");
  byte_count_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (link_stop_i && dcnt_reg != ecr_pkg::WR_DATA_BYTES) |-> !wr_fire)
    else $error("write fired with wrong byte count");
  confirm_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_arrive && wr_conf != conf_need && !nv_load)
    |=> $stable({scheme_reg, lock_reg, zone_guard_bits_reg}) && !nv_write_reg)
    else $error("bad confirmation changed the register");
  lock_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (lock_reg && !nv_load) |=> lock_reg && $stable({scheme_reg, zone_guard_bits_reg}))
    else $error("locked register changed");
  ecc_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    array_read_done_i |=> ecc_used_flag_reg == $past(array_read_ecc_i))
    else $error("correction latch did not follow last read");
  zone_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (scheme_reg && !nv_load && !wr_ok) |=> arr_blk_reg == zone_guard_bits_reg[
      $past(array_wr_addr_i[ecr_pkg::ZONE_MSB:ecr_pkg::ZONE_LSB])])
    else $error("zone protection wrong");
  pin_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!scheme_reg && !nv_load && !wr_ok) |=> arr_blk_reg == $past(wp_s2_reg)
    && sec_blk_reg == $past(wp_s2_reg))
    else $error("pin protection wrong");
  unimpl_zero_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    cfg_view_reg[14:10] == 5'h00)
    else $error("unimplemented bits not zero");

endmodule // ecr_config_reg

//--- ecr_host_model.sv
// Two-wire bus host model facing the link side of the config register.
`timescale 1ns/10ps
module ecr_host_model (
  // Link signals towards the device.
  output logic       lclk_o    = 1'b0,
  output logic       start_o   = 1'b0,
  output logic       stop_o    = 1'b0,
  output logic       sda_o     = 1'b1,
  // Results of the last byte.
  output logic       rd_vld_o  = 1'b0,
  output logic [7:0] rd_byte_o = 8'h00,
  output logic       ack_o     = 1'b0,
  // Resolved data wire.
  input  wire logic  wire_i
);
  logic run = 1'b0;

  // The clock stands still between frames, as a real host leaves it.
  always #6 lclk_o = run & ~lclk_o;

  task put(input logic s, input logic p, input logic d);
    @(posedge lclk_o);
    start_o <= s;
    stop_o <= p;
    sda_o <= d;
    rd_vld_o <= 1'b0;
  endtask

  task idle(input int n);
    run = 1'b1;
    repeat (n) put(1'b0, 1'b0, 1'b1);
  endtask

  task send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) put(1'b0, 1'b0, b[i]);
    put(1'b0, 1'b0, 1'b1);
    @(negedge lclk_o);
    ack_o = ~wire_i;
  endtask

  // The host releases the line while the device sends, so the pull-up shows.
  task recv(input logic last);
    for (int i = 7; i >= 0; i--) begin
      put(1'b0, 1'b0, 1'b1);
      @(negedge lclk_o);
      rd_byte_o[i] = wire_i;
    end
    rd_vld_o <= 1'b1;
    put(1'b0, 1'b0, last);
  endtask

  task stop();
    put(1'b0, 1'b1, 1'b1);
    put(1'b0, 1'b0, 1'b1);
    @(posedge lclk_o);
    run = 1'b0;
  endtask
endmodule  // ecr_host_model

//--- ecr_config_reg_tb.sv
// Self-checking bench for the configuration register block.
`timescale 1ns/10ps
module ecr_config_reg_tb;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        lclk, lstart, lstop, hsda, rd_vld, hack, dsda, doe;
  logic        nvw, scheme, lock, blk, sblk;
  logic [7:0]  rd_byte, zone;
  logic [7:0]  nv_zone = 8'h00;
  logic        nv_sch = 1'b0;
  logic [2:0]  cs = 3'h0;
  logic        wp = 1'b0;
  logic        rdone = 1'b0;
  logic        recc = 1'b0;
  logic [14:0] waddr = 15'h0000;
  logic [31:0] seed = 32'h0000005d;
  logic [7:0]  q_rd[$];
  logic [9:0]  q_nv[$];
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cycles = 0;
  wire         sda_w = doe ? dsda : hsda;

  always #50 sys_clk_i = ~sys_clk_i;

  ecr_config_reg DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(lclk),
    .link_start_i(lstart), .link_stop_i(lstop), .link_sda_i(sda_w), .link_sda_o(dsda),
    .link_sda_oe_o(doe), .chip_select_bit2_i(cs[2]), .chip_select_bit1_i(cs[1]),
    .chip_select_bit0_i(cs[0]), .wp_pin_i(wp), .array_read_done_i(rdone),
    .array_read_ecc_i(recc), .array_wr_addr_i(waddr), .array_wr_blocked_o(blk),
    .sec_wr_blocked_o(sblk), .nv_scheme_i(nv_sch), .nv_lock_i(1'b0), .nv_zone_i(nv_zone),
    .nv_write_o(nvw), .protect_scheme_select_o(scheme), .lock_o(lock),
    .zone_guard_bits_o(zone));

  ecr_host_model host (.lclk_o(lclk), .start_o(lstart), .stop_o(lstop), .sda_o(hsda),
    .rd_vld_o(rd_vld), .rd_byte_o(rd_byte), .ack_o(hack), .wire_i(sda_w));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Only A15, A11 and A10 are fixed; the other address bits are random.
  function automatic logic [7:0] wa();
    return 8'h88 | (8'(xs()) & 8'h73);
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  always @(posedge rd_vld) begin
    if (q_rd.size() == 0) check(16'h1, 16'h0);
    else check(16'(rd_byte), 16'(q_rd.pop_front()));
  end

  always @(posedge sys_clk_i) if (nvw === 1'b1) begin
    repeat (2) @(posedge sys_clk_i);
    if (q_nv.size() == 0) check(16'h1, 16'h0);
    else check(16'({scheme, lock, zone}), 16'(q_nv.pop_front()));
  end

  task hdr(input logic [7:0] dev, input logic [7:0] wa_hi, input logic exp_ack);
    host.idle(10);
    host.put(1'b1, 1'b0, 1'b1);
    host.send(dev);
    check(16'(hack), 16'(exp_ack));
    if (exp_ack) begin
      host.send(wa_hi);
      host.send(8'(xs()));
    end
  endtask

  task wr(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] conf,
          input logic three);
    hdr({4'hb, cs, 1'b0}, wa(), 1'b1);
    host.send(hi);
    check(16'(hack), 16'h1);
    host.send(lo);
    if (three) host.send(conf);
    check(16'(hack), 16'h1);
    host.stop();
    repeat (12) @(posedge sys_clk_i);
  endtask

  task rd(input logic [7:0] wa_hi, input int n);
    hdr({4'hb, cs, 1'b0}, wa_hi, 1'b1);
    host.put(1'b1, 1'b0, 1'b1);
    host.send({4'hb, cs, 1'b1});
    check(16'(hack), 16'h1);
    for (int i = 0; i < n; i++) host.recv(i == n - 1);
    host.stop();
  endtask

  task exp_rd(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) q_rd.push_back(i[0] ? w[7:0] : w[15:8]);
  endtask

  initial begin
    logic [7:0] z;
    nv_zone = 8'(xs());
    cs = 3'(xs());
    nv_sch = 1'(xs());
    fork
      host.idle(40);
    join_none
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    exp_rd({6'h00, nv_sch, 1'b0, nv_zone}, 2);
    rd(wa(), 2);
    z = 8'(xs());
    q_nv.push_back({2'b10, z});
    wr(8'h02, z, 8'h66, 1'b1);
    exp_rd({8'h02, z}, 3);
    rd(wa(), 3);
    wp <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      @(posedge sys_clk_i);
      waddr <= {3'(n), 12'(xs())};
      repeat (5) @(posedge sys_clk_i);
      check(16'(blk), 16'(z[n]));
    end
    wr(8'h00, ~z, 8'h99, 1'b1);
    wr(8'h00, ~z, 8'h66, 1'b0);
    hdr({4'ha, cs, 1'b0}, 8'h88, 1'b0);
    host.stop();
    hdr({4'hb, ~cs, 1'b0}, 8'h88, 1'b0);
    host.stop();
    q_rd.push_back(8'hff);
    rd(8'h8c, 1);
    q_nv.push_back({2'b00, ~z});
    wr(8'h00, ~z, 8'h66, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wp <= ~i[0];
      repeat (6) @(posedge sys_clk_i);
      check(16'(blk), 16'(!i[0]));
      check(16'(sblk), 16'(!i[0]));
    end
    for (int i = 0; i < 2; i++) begin
      rdone <= 1'b1;
      recc <= ~i[0];
      @(posedge sys_clk_i);
      rdone <= 1'b0;
      recc <= i[0];
      exp_rd({~i[0], 7'h00, ~z}, 1);
      rd(wa(), 1);
      @(posedge sys_clk_i);
    end
    q_nv.push_back({2'b01, z});
    wr(8'h01, z, 8'h99, 1'b1);
    wr(8'h00, 8'h00, 8'h66, 1'b1);
    exp_rd({8'h01, z}, 2);
    rd(wa(), 2);
    check(16'(q_nv.size() + q_rd.size()), 16'h0);
    finish_test();
  end
endmodule  // ecr_config_reg_tb
